//--- rtl/system_irq_status_mask_clear.sv
/*
  Interrupt control and status word of the system controller, seen by
  the host processor over a plain register port. Holds pending flags,
  per-source enables, write-one-to-clear bits and the serial port gate,
  and drives one level interrupt toward the processor.
  Assumes all event inputs are one-cycle pulses (serial inputs levels)
  from logic on clk, and a master that never asserts both strobes.
*/
// Summary of operation
// R1: Bit 6 latches a bus error seen while acting as PCI target.
// R2: Bit 7 latches address or data parity errors of listed cycles.
// R3: Bits 15:8 enable or block the eight low-byte sources in order.
// R4: Bits 17:16 read one once channel 3 or 4 transfer completes.
// R5: Bits 18 and 19 enable channel 3 and 4 completion interrupts.
// R6: Writing one to bit 20 or 21 clears channel 3 or 4; reads zero.
// R7: Bit 22 shows the active serial port interrupt summary.
// R8: Bit 23 gates all individually enabled serial sources; reads zero.
// R9: All serial source enables cleared drops the serial summary flag.
// R10: Writing one to bits 31:24 clears low-byte pending flags; reads zero.
// R11: Bits 5:0 latch cpu bus error, dma done, mailbox and dma bus error.
// R12: Word at offset 0x50, zero at reset, flags hold until cleared.
// R13: Interrupt high while any enabled flag pends; writing zero clears nothing.
`timescale 1ns/1ps
`default_nettype none

module system_irq_status_mask_clear (
  input  wire logic                                  clk,
  input  wire logic                                  resetn,
  // Register port
  input  wire logic [irq_csr_pkg::ADDR_W-1:0]        reg_addr,
  input  wire logic [irq_csr_pkg::DATA_W-1:0]        reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic      [irq_csr_pkg::DATA_W-1:0]        reg_rdata,
  // Event pulses from the surrounding controller
  input  wire logic                                  cpu_bus_err_evt,
  input  wire logic                                  dma_ch1_done_evt,
  input  wire logic                                  dma_ch2_done_evt,
  input  wire logic                                  mailbox_one_evt,
  input  wire logic                                  mailbox_two_evt,
  input  wire logic                                  dma_bus_err_evt,
  input  wire logic                                  pci_tgt_bus_err_evt,
  input  wire logic                                  addr_par_tgt_evt,
  input  wire logic                                  data_par_tgt_wr_evt,
  input  wire logic                                  data_par_mst_rd_evt,
  input  wire logic                                  dma_ch3_done_evt,
  input  wire logic                                  dma_ch4_done_evt,
  // Serial port interrupt sources and its own enable bits
  input  wire logic [irq_csr_pkg::SERIAL_SRC_N-1:0]  serial_port_sources,
  input  wire logic [irq_csr_pkg::SERIAL_SRC_N-1:0]  serial_port_source_enables,
  // Level interrupt to the processor
  output logic                                       cpu_irq
);

  localparam int unsigned LO_N = irq_csr_pkg::LOW_SRC_N;
  localparam int unsigned HI_N = irq_csr_pkg::HIGH_SRC_N;
  localparam int unsigned N = irq_csr_pkg::SRC_N;
  localparam int unsigned DW = irq_csr_pkg::DATA_W;

  // Address decode, shared by read and write paths
  function automatic logic hits_csr(
    input logic [irq_csr_pkg::ADDR_W-1:0] a
  );
    return a == irq_csr_pkg::IRQ_CSR_ADDR;
  endfunction : hits_csr

  typedef struct packed {
    logic [LO_N-1:0] en_lo;       // Low-byte source enables
    logic [HI_N-1:0] en_hi;       // Channel 3 and 4 enables
    logic            serial_gate; // Global serial port gate
    logic [DW-1:0]   rdata;       // Read data, valid one cycle
    logic            irq;         // Registered interrupt output
  } csr_state_t;

  csr_state_t state_q;
  csr_state_t state_d;

  logic [N-1:0] set_vec;
  logic [N-1:0] clr_vec;
  logic [N-1:0] pending;
  logic [N-1:0] enables;
  logic         serial_port_irq_flag;
  logic         wr_hit;
  logic         rd_hit;

  assign wr_hit = reg_wr & hits_csr(reg_addr);
  assign rd_hit = reg_rd & hits_csr(reg_addr);

  // Event sources in pending-vector order
  always_comb begin
    set_vec = '0;
    set_vec[irq_csr_pkg::SRC_CPU_BUS_ERR] = cpu_bus_err_evt;   // R11
    set_vec[irq_csr_pkg::SRC_DMA_CH1] = dma_ch1_done_evt;      // R11
    set_vec[irq_csr_pkg::SRC_DMA_CH2] = dma_ch2_done_evt;      // R11
    set_vec[irq_csr_pkg::SRC_MAILBOX_ONE] = mailbox_one_evt;   // R11
    set_vec[irq_csr_pkg::SRC_MAILBOX_TWO] = mailbox_two_evt;   // R11
    set_vec[irq_csr_pkg::SRC_DMA_BUS_ERR] = dma_bus_err_evt;   // R11
    set_vec[irq_csr_pkg::SRC_PCI_BUS_ERR] = pci_tgt_bus_err_evt; // R1
    set_vec[irq_csr_pkg::SRC_PARITY_ERR] = addr_par_tgt_evt
                                         | data_par_tgt_wr_evt
                                         | data_par_mst_rd_evt; // R2
    set_vec[irq_csr_pkg::SRC_DMA_CH3] = dma_ch3_done_evt;      // R4
    set_vec[irq_csr_pkg::SRC_DMA_CH4] = dma_ch4_done_evt;      // R4
  end

  // Clear strobes: only ones written to the wipe fields act
  always_comb begin
    clr_vec = '0;
    if (wr_hit) begin
      clr_vec[LO_N-1:0] =
        reg_wdata[irq_csr_pkg::WIPE_LO_POS +: LO_N]; // R10 R13
      clr_vec[N-1:LO_N] =
        reg_wdata[irq_csr_pkg::WIPE_HI_POS +: HI_N]; // R6 R13
    end
  end

  // Flags hold until software clears them, reads leave them alone
  sticky_flags #(
    .N (N)
  ) u_pending (
    .clk    (clk),
    .resetn (resetn),
    .set    (set_vec),
    .clr    (clr_vec),
    .flags  (pending)
  ); // R12

  serial_irq_merge u_serial (
    .clk            (clk),
    .resetn         (resetn),
    .sources        (serial_port_sources),
    .source_enables (serial_port_source_enables),
    .gate           (state_q.serial_gate),
    .flag           (serial_port_irq_flag)
  ); // R9

  assign enables = {state_q.en_hi, state_q.en_lo};

  // Register writes, read data and interrupt output
  always_comb begin
    state_d = state_q;
    state_d.rdata = '0; // Unmapped or idle reads return zero
    if (wr_hit) begin
      state_d.en_lo =
        reg_wdata[irq_csr_pkg::EN_LO_POS +: LO_N]; // R3
      state_d.en_hi =
        reg_wdata[irq_csr_pkg::EN_HI_POS +: HI_N]; // R5
      state_d.serial_gate =
        reg_wdata[irq_csr_pkg::SERIAL_GATE_POS]; // R8
    end
    if (rd_hit) begin
      // Wipe bits and the gate read back as zero
      state_d.rdata[irq_csr_pkg::PEND_LO_POS +: LO_N] =
        pending[LO_N-1:0]; // R1 R2 R11
      state_d.rdata[irq_csr_pkg::EN_LO_POS +: LO_N] = state_q.en_lo; // R3
      state_d.rdata[irq_csr_pkg::PEND_HI_POS +: HI_N] =
        pending[N-1:LO_N]; // R4
      state_d.rdata[irq_csr_pkg::EN_HI_POS +: HI_N] = state_q.en_hi; // R5
      state_d.rdata[irq_csr_pkg::SERIAL_FLAG_POS] =
        serial_port_irq_flag; // R7
    end
    // Serial summary is already gated, so it joins directly
    state_d.irq = (|(pending & enables)) | serial_port_irq_flag; // R13
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0; // R12
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata = state_q.rdata;
  assign cpu_irq = state_q.irq;

endmodule : system_irq_status_mask_clear

`default_nettype wire

//--- rtl/irq_csr_pkg.sv
/*
  Constants shared by the interrupt control and status block: register
  offset, bit positions of every field, widths and reset values.
  Assumes a byte-addressed register port with 32-bit data.
*/
package irq_csr_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Byte offset of the interrupt control and status word
  localparam logic [ADDR_W-1:0] IRQ_CSR_ADDR = 8'h50;
  localparam logic [DATA_W-1:0] IRQ_CSR_RESET = 32'h0000_0000;

  // Eight sources of the low byte, one pending bit each, in bit order:
  // cpu bus error, dma ch1 done, dma ch2 done, mailbox one, mailbox two,
  // dma bus error, pci bus error, parity error
  localparam int unsigned LOW_SRC_N = 8;
  // Two further sources: dma ch3 done, dma ch4 done
  localparam int unsigned HIGH_SRC_N = 2;
  localparam int unsigned SRC_N = LOW_SRC_N + HIGH_SRC_N;

  // Serial port interrupt sources seen by the summary flag
  localparam int unsigned SERIAL_SRC_N = 4;

  // Field positions (lowest bit of each field)
  localparam int unsigned PEND_LO_POS = 0;   // bits 7:0, read only
  localparam int unsigned EN_LO_POS = 8;     // bits 15:8, read/write
  localparam int unsigned PEND_HI_POS = 16;  // bits 17:16, read only
  localparam int unsigned EN_HI_POS = 18;    // bits 19:18, read/write
  localparam int unsigned WIPE_HI_POS = 20;  // bits 21:20, write only
  localparam int unsigned SERIAL_FLAG_POS = 22;
  localparam int unsigned SERIAL_GATE_POS = 23;
  localparam int unsigned WIPE_LO_POS = 24;  // bits 31:24, write only

  // Index of each source within the internal pending vector
  localparam int unsigned SRC_CPU_BUS_ERR = 0;
  localparam int unsigned SRC_DMA_CH1 = 1;
  localparam int unsigned SRC_DMA_CH2 = 2;
  localparam int unsigned SRC_MAILBOX_ONE = 3;
  localparam int unsigned SRC_MAILBOX_TWO = 4;
  localparam int unsigned SRC_DMA_BUS_ERR = 5;
  localparam int unsigned SRC_PCI_BUS_ERR = 6;
  localparam int unsigned SRC_PARITY_ERR = 7;
  localparam int unsigned SRC_DMA_CH3 = 8;
  localparam int unsigned SRC_DMA_CH4 = 9;

endpackage : irq_csr_pkg

//--- rtl/sticky_flags.sv
/*
  Bank of sticky pending flags: a set input latches a flag until a clear
  strobe removes it; a set in the clear cycle wins.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
  parameter int unsigned N = 10
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clr,
  output logic      [N-1:0] flags
);

  typedef struct packed {
    logic [N-1:0] flags;
  } sticky_state_t;

  sticky_state_t state_q;
  sticky_state_t state_d;

  // Per bit: set beats clear so no event is lost
  always_comb begin
    state_d = state_q;
    for (int i = 0; i < N; i++) begin
      state_d.flags[i] = set[i] | (state_q.flags[i] & ~clr[i]);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flags = state_q.flags;

endmodule : sticky_flags

`default_nettype wire

//--- rtl/serial_irq_merge.sv
/*
  Summary of the serial port interrupt: any source that is enabled in
  the serial port's own enable bits, passed only while the global gate
  is set. Registered once.
  Assumes sources and enables are levels from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_irq_merge (
  input  wire logic                              clk,
  input  wire logic                              resetn,
  input  wire logic [irq_csr_pkg::SERIAL_SRC_N-1:0] sources,
  input  wire logic [irq_csr_pkg::SERIAL_SRC_N-1:0] source_enables,
  input  wire logic                              gate,
  output logic                                   flag
);

  typedef struct packed {
    logic flag;
  } merge_state_t;

  merge_state_t state_q;
  merge_state_t state_d;

  // All enables low drops the summary at the next clock edge
  always_comb begin
    state_d = state_q;
    state_d.flag = gate & (|(sources & source_enables)); // R8 R9
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flag = state_q.flag;

endmodule : serial_irq_merge

`default_nettype wire

//--- verification/irq_csr_checker_properties.sv
/*
  Checker for the interrupt word: read data on the register port
  against the event inputs and the serial port enables.
  Assumes one clock domain and binding to the top module by name.
*/
`timescale 1ns/1ps
`default_nettype none

module irq_csr_checker (
  input wire logic                                   clk,
  input wire logic                                   resetn,
  input wire logic [irq_csr_pkg::ADDR_W-1:0]         reg_addr,
  input wire logic                                   reg_rd,
  input wire logic [irq_csr_pkg::DATA_W-1:0]         reg_rdata,
  input wire logic                                   cpu_bus_err_evt,
  input wire logic                                   pci_tgt_bus_err_evt,
  input wire logic                                   addr_par_tgt_evt,
  input wire logic                                   data_par_tgt_wr_evt,
  input wire logic                                   data_par_mst_rd_evt,
  input wire logic                                   dma_ch3_done_evt,
  input wire logic [irq_csr_pkg::SERIAL_SRC_N-1:0]   serial_port_source_enables
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // A read of the word itself; other offsets must answer zero
  sequence s_hit;
    reg_rd && reg_addr == irq_csr_pkg::IRQ_CSR_ADDR;
  endsequence
  sequence s_ser_off;
    (serial_port_source_enables == 4'h0) [*2] ##0 s_hit;
  endsequence

  property p_wipe_hi; $past(reg_rd) |-> reg_rdata[21:20] == 2'h0; endproperty
  property p_wipe_lo; $past(reg_rd) |-> reg_rdata[31:24] == 8'h00; endproperty
  property p_gate; $past(reg_rd) |-> !reg_rdata[23]; endproperty
  property p_pci; pci_tgt_bus_err_evt ##1 s_hit |=> reg_rdata[6]; endproperty
  property p_par;
    (addr_par_tgt_evt || data_par_tgt_wr_evt || data_par_mst_rd_evt)
      ##1 s_hit |=> reg_rdata[7];
  endproperty
  property p_dma_ch3_done; dma_ch3_done_evt ##1 s_hit |=> reg_rdata[16]; endproperty
  property p_cpu; cpu_bus_err_evt ##1 s_hit |=> reg_rdata[0]; endproperty
  property p_ser; s_ser_off |=> !reg_rdata[22]; endproperty
  property p_unmap;
    reg_rd && reg_addr != irq_csr_pkg::IRQ_CSR_ADDR |=> reg_rdata == 32'h0;
  endproperty

  a_wipe_hi: assert property (p_wipe_hi)
    else $error("clear bits 21:20 read as one");
  a_wipe_lo: assert property (p_wipe_lo)
    else $error("clear bits 31:24 read as one");
  a_gate: assert property (p_gate)
    else $error("serial gate read as one");
  a_pci: assert property (p_pci)
    else $error("pci bus error flag not set");
  a_par: assert property (p_par)
    else $error("parity flag not set");
  a_dma_ch3_done: assert property (p_dma_ch3_done)
    else $error("channel 3 done flag not set");
  a_cpu: assert property (p_cpu)
    else $error("cpu bus error flag not set");
  a_ser: assert property (p_ser)
    else $error("serial flag stays with enables off");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
endmodule : irq_csr_checker

bind system_irq_status_mask_clear irq_csr_checker u_chk (.*);

`default_nettype wire

//--- verification/event_source.sv
/*
  Model of the surrounding controller: turns a request from the bench
  into a one-cycle event pulse on the next clock.
  Assumes the same clock and reset as the block.
*/
`timescale 1ns/1ps
`default_nettype none

module event_source (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [11:0] fire,
  output logic      [11:0] evt
);
  // Registered so events launch on an edge, like real source logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) evt <= 12'h000;
    else evt <= fire;
  end
endmodule : event_source

`default_nettype wire

//--- verification/system_irq_status_mask_clear_test.sv
/*
  Self-checking bench for the interrupt word: register reads and
  writes, every event source, masking, clearing and the serial gate.
  Assumes the event source model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

module system_irq_status_mask_clear_test;
  localparam logic [31:0] EN_ALL = 32'h000C_FF00;
  logic                               clk, resetn, reg_wr, reg_rd, cpu_irq;
  logic [irq_csr_pkg::ADDR_W-1:0]     reg_addr;
  logic [31:0]                        reg_wdata, reg_rdata;
  logic [11:0]                        fire, evt;
  logic [3:0]                         ser_src, ser_en;
  int                                 num_errors, n_compared, b;

  event_source u_src (.clk(clk), .resetn(resetn), .fire(fire), .evt(evt));
  system_irq_status_mask_clear u_dut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_bus_err_evt(evt[0]),
    .dma_ch1_done_evt(evt[1]), .dma_ch2_done_evt(evt[2]),
    .mailbox_one_evt(evt[3]), .mailbox_two_evt(evt[4]),
    .dma_bus_err_evt(evt[5]), .pci_tgt_bus_err_evt(evt[6]),
    .addr_par_tgt_evt(evt[7]), .data_par_tgt_wr_evt(evt[8]),
    .data_par_mst_rd_evt(evt[9]), .dma_ch3_done_evt(evt[10]),
    .dma_ch4_done_evt(evt[11]), .serial_port_sources(ser_src),
    .serial_port_source_enables(ser_en), .cpu_irq(cpu_irq));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : rd

  task automatic pulse(input int i);
    @(posedge clk) fire <= 12'h001 << i;
    // No idle edge here: a read right after lands one cycle behind the
    // event, the spacing that the checker's flag properties look for
    @(posedge clk) fire <= 12'h000;
  endtask : pulse

  // Status bit of each event; the three parity inputs share bit 7
  function automatic int sbit(input int i);
    return i < 7 ? i : (i < 10 ? 7 : i + 6);
  endfunction : sbit

  // Hang guard, well beyond the couple of hundred cycles of the sequence
  initial begin
    #200000;
    num_errors++;
    summarize();
  end

  // Main sequence
  initial begin
    num_errors = 0; n_compared = 0; resetn = 1'b0;
    reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
    fire = '0; ser_src = '0; ser_en = '0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h50, 32'h0);
    check({31'h0, cpu_irq}, 32'h0);
    rd(8'h54, 32'h0);
    wr(8'h50, 32'hFFFF_FFFF);
    rd(8'h50, EN_ALL);
    wr(8'h54, 32'h0);
    rd(8'h50, EN_ALL);
    for (int i = 0; i < 12; i++) begin
      pulse(i);
      b = sbit(i);
      rd(8'h50, EN_ALL | (32'h1 << b));
      check({31'h0, cpu_irq}, 32'h1);
      wr(8'h50, EN_ALL);
      rd(8'h50, EN_ALL | (32'h1 << b));
      wr(8'h50, EN_ALL | (32'h1 << (b < 8 ? b + 24 : b + 4)));
      rd(8'h50, EN_ALL);
      check({31'h0, cpu_irq}, 32'h0);
    end
    wr(8'h50, 32'h0);
    pulse(0);
    rd(8'h50, 32'h0000_0001);
    check({31'h0, cpu_irq}, 32'h0);
    wr(8'h50, 32'h0100_0000);
    pulse(10);
    rd(8'h50, 32'h0001_0000);
    check({31'h0, cpu_irq}, 32'h0);
    wr(8'h50, 32'h0004_0000);
    rd(8'h50, 32'h0005_0000);
    check({31'h0, cpu_irq}, 32'h1);
    wr(8'h50, 32'h0010_0000);
    rd(8'h50, 32'h0);
    ser_src <= 4'h1; ser_en <= 4'h1;
    wr(8'h50, 32'h0080_0000);
    repeat (2) @(posedge clk);
    rd(8'h50, 32'h0040_0000);
    check({31'h0, cpu_irq}, 32'h1);
    ser_en <= 4'h0;
    repeat (2) @(posedge clk);
    rd(8'h50, 32'h0);
    ser_en <= 4'h1;
    wr(8'h50, 32'h0);
    repeat (2) @(posedge clk);
    rd(8'h50, 32'h0);
    // Reset in mid-run must drop a pending flag and every enable
    wr(8'h50, EN_ALL);
    pulse(0);
    repeat (2) @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h50, 32'h0);
    check({31'h0, cpu_irq}, 32'h0);
    summarize();
  end
endmodule : system_irq_status_mask_clear_test

`default_nettype wire
